// ### bench/cds_host_model.sv
// host model for the settings bank: drives bit clock, word start and receive data
// assumes one word at a time, called from the bench; bit clock stands still between words
`timescale 1ns/1ps

module cds_host_model (
   // link lines driven by the host
   output logic sclk,
   output logic word_start_in,
   output logic serial_rx_data,
   // device answer
   input wire logic serial_tx_data,
   input wire logic serial_tx_oe
);
   localparam realtime HALF = 3.0;
   logic [63:0] rx_word;
   logic oe_all;
   logic oe_after;

   // a few idle bit clocks so reset sees the link domain
   initial begin
      sclk = 1'b0;
      word_start_in = 1'b0;
      serial_rx_data = 1'b0;
      #1.3;
      repeat (6) begin
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
   end

   // one 64-bit word: low then high word start sample, then bits msb first
   task automatic xfer(input logic [63:0] w);
      integer i;
      oe_all = 1'b1;
      #0.7; // keep bit clock edges off the system clock edges
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
      #HALF sclk = 1'b1;
      word_start_in = 1'b1;
      #HALF sclk = 1'b0;
      for (i = 63; i >= 0; i--) begin
         #HALF sclk = 1'b1;
         word_start_in = 1'b0;
         serial_rx_data = w[i];
         #HALF sclk = 1'b0;
         rx_word[i] = serial_tx_oe ? serial_tx_data : ~serial_tx_data;
         oe_all = oe_all & serial_tx_oe;
      end
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
      oe_after = serial_tx_oe;
   endtask
endmodule

// ### bench/cds_settings_chk.sv
// assertions on the settings bank outputs in the system clock domain
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps

module cds_settings_chk (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // status inputs
   input wire logic autocal_busy,
   input wire logic adc_overrange,
   // settings outputs
   input wire cds_pkg::cds_data_set_type data_settings,
   input wire cds_pkg::cds_ctrl_set_type ctrl_settings,
   input wire logic [1:0] signal_bits,
   input wire logic [1:0] signal_pins_oe,
   input wire logic left_dac_mute,
   input wire logic right_dac_mute,
   input wire logic monitor_off,
   input wire logic mic_boost_on,
   input wire logic adc_invalid_flag,
   input wire logic overrange_flag,
   input wire logic data_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // derived flags against their fields
   left_mute_a: assert property (left_dac_mute == (data_settings.left_dac_atten == 6'h3F))
      else $error("left dac mute wrong");
   right_mute_a: assert property (right_dac_mute == (data_settings.right_dac_atten == 6'h3F))
      else $error("right dac mute wrong");
   monitor_off_a: assert property (monitor_off == (data_settings.monitor_mix_atten == 4'hF))
      else $error("monitor off wrong");
   mic_boost_a: assert property (mic_boost_on ==
      (data_settings.input_select & ~ctrl_settings.mic_boost_bypass))
      else $error("mic boost wrong");
   // status flags and signalling pins
   adi_busy_a: assert property (autocal_busy [*3] |-> adc_invalid_flag)
      else $error("invalid flag low while calibrating");
   adi_clear_a: assert property ($fell(autocal_busy) ##1 (!autocal_busy) [*3] |->
      !adc_invalid_flag)
      else $error("invalid flag not cleared");
   ovr_set_a: assert property (adc_overrange |-> ##[1:3] overrange_flag)
      else $error("overrange not flagged");
   sig_pins_a: assert property (($stable(signal_bits)) [*3] |->
      signal_pins_oe == ~signal_bits)
      else $error("signalling pins wrong");
   // defaults after reset and after a mode change
   reset_def_a: assert property ($rose(reset_n) |->
      data_settings == cds_pkg::DATA_DEFAULT
      && ctrl_settings == cds_pkg::CTRL_DEFAULT && signal_bits == 2'h3)
      else $error("reset defaults wrong");
   mode_def_a: assert property ($rose(data_mode) |-> ##[0:3]
      data_settings == cds_pkg::DATA_DEFAULT)
      else $error("mode change defaults wrong");

   cover property ($rose(data_mode));
   cover property ($fell(overrange_flag));
   cover property ($fell(adc_invalid_flag));
endmodule

bind cds_settings cds_settings_chk i_cds_settings_chk (.clk(clk), .reset_n(reset_n),
   .autocal_busy(autocal_busy), .adc_overrange(adc_overrange), .data_settings(data_settings),
   .ctrl_settings(ctrl_settings), .signal_bits(signal_bits), .signal_pins_oe(signal_pins_oe),
   .left_dac_mute(left_dac_mute), .right_dac_mute(right_dac_mute), .monitor_off(monitor_off),
   .mic_boost_on(mic_boost_on), .adc_invalid_flag(adc_invalid_flag),
   .overrange_flag(overrange_flag), .data_mode(data_mode));

// ### bench/cds_settings_tb.sv
// self-checking bench for the settings bank
// assumes the host model drives the link and the checker binds itself
`timescale 1ns/1ps

module cds_settings_tb;
   logic clk, reset_n, data_mode_pin, power_down, autocal_busy, adc_overrange;
   logic sclk, word_start_in, serial_rx_data, serial_tx_data, serial_tx_oe;
   logic [1:0] ext_pins, signal_pins_in, signal_pins_out, signal_pins_oe, signal_bits;
   cds_pkg::cds_data_set_type data_settings;
   cds_pkg::cds_ctrl_set_type ctrl_settings;
   logic left_dac_mute, right_dac_mute, monitor_off, mic_boost_on;
   logic adc_invalid_flag, overrange_flag, data_mode;
   int bad_count = 0;
   int n_tests = 0;
   localparam logic [63:0] CW = 64'h152E3601_40000000;
   localparam logic [63:0] DW = 64'hA5A55A5A_BF45BF09;
   localparam logic [63:0] DWC = 64'hA5A55A5A_BF459F09;
   localparam logic [63:0] DW1 = 64'hA5A55A5A_BFC5BF09;

   // open-collector pins: pulled high unless the device or ext_pins pulls low
   assign signal_pins_in = ext_pins & ~signal_pins_oe;

   cds_settings i_cds_settings (.clk(clk), .reset_n(reset_n), .sclk(sclk),
      .serial_rx_data(serial_rx_data), .word_start_in(word_start_in),
      .data_mode_pin(data_mode_pin), .serial_tx_data(serial_tx_data),
      .serial_tx_oe(serial_tx_oe), .signal_pins_in(signal_pins_in),
      .signal_pins_out(signal_pins_out), .signal_pins_oe(signal_pins_oe),
      .power_down(power_down), .autocal_busy(autocal_busy), .adc_overrange(adc_overrange),
      .data_settings(data_settings), .ctrl_settings(ctrl_settings), .signal_bits(signal_bits),
      .left_dac_mute(left_dac_mute), .right_dac_mute(right_dac_mute),
      .monitor_off(monitor_off), .mic_boost_on(mic_boost_on),
      .adc_invalid_flag(adc_invalid_flag), .overrange_flag(overrange_flag),
      .data_mode(data_mode));

   cds_host_model i_cds_host_model (.sclk(sclk), .word_start_in(word_start_in),
      .serial_rx_data(serial_rx_data), .serial_tx_data(serial_tx_data),
      .serial_tx_oe(serial_tx_oe));

   // compare and count
   task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask

   // settings reach the outputs about four clocks after the word
   task automatic settle();
      repeat (10) @(posedge clk);
   endtask

   task automatic send(input logic [63:0] w);
      i_cds_host_model.xfer(w);
      settle();
   endtask

   task automatic t_reset();
      chk(data_settings, cds_pkg::DATA_DEFAULT, "data defaults");
      chk(ctrl_settings, cds_pkg::CTRL_DEFAULT, "ctrl defaults");
      chk({signal_bits, adc_invalid_flag, overrange_flag}, 4'hE, "status defaults");
      chk({left_dac_mute, right_dac_mute, monitor_off, data_mode}, 4'hE, "mutes");
      $display("done reset");
   endtask

   task automatic t_ctrl();
      send(CW);
      chk(i_cds_host_model.oe_all, 1'h1, "control mode drives");
      chk(ctrl_settings, 20'hBB8D9, "control word");
      chk({signal_bits, signal_pins_oe, signal_pins_out}, 6'h18, "signalling bits");
      send(CW);
      chk(i_cds_host_model.rx_word, 64'h152E3601_40002200, "control echo");
      chk(i_cds_host_model.oe_after, 1'h0, "release after word");
      $display("done control");
   endtask

   task automatic t_data();
      @(posedge clk);
      data_mode_pin <= 1'b1;
      settle();
      chk(data_mode, 1'h1, "data mode");
      chk(data_settings, cds_pkg::DATA_DEFAULT, "mode change defaults");
      chk({ctrl_settings, signal_bits}, {20'hBB8D9, 2'h1}, "kept fields");
      send(DW);
      chk(data_settings, 28'hBF8BF09, "first data word");
      chk({left_dac_mute, right_dac_mute, monitor_off, mic_boost_on}, 4'h8, "derived");
      chk({signal_bits, adc_invalid_flag, overrange_flag}, 4'hA, "status kept");
      ext_pins <= 2'h1;
      send(DW);
      chk(i_cds_host_model.rx_word, 64'h00000000_BFC51F09, "data echo");
      ext_pins <= 2'h3;
      $display("done data");
   endtask

   task automatic t_status();
      @(posedge clk);
      adc_overrange <= 1'b1;
      @(posedge clk);
      adc_overrange <= 1'b0;
      repeat (20) @(posedge clk);
      chk(overrange_flag, 1'h1, "sticky overrange");
      send(DW);
      chk(overrange_flag, 1'h1, "one written");
      send(DWC);
      chk(overrange_flag, 1'h0, "zero written");
      @(posedge clk);
      autocal_busy <= 1'b1;
      repeat (6) @(posedge clk);
      autocal_busy <= 1'b0;
      settle();
      chk(adc_invalid_flag, 1'h0, "calibration done");
      send(DW1);
      chk({adc_invalid_flag, overrange_flag}, 2'h0, "status writes ignored");
      autocal_busy <= 1'b1;
      repeat (6) @(posedge clk);
      chk(adc_invalid_flag, 1'h1, "calibrating");
      autocal_busy <= 1'b0;
      data_mode_pin <= 1'b0;
      settle();
      data_mode_pin <= 1'b1;
      settle();
      chk(data_settings, cds_pkg::DATA_DEFAULT, "second mode change");
      chk({signal_bits, adc_invalid_flag}, 3'h4, "kept after mode change");
      $display("done status");
   endtask

   task automatic t_pwrdn();
      @(posedge clk);
      power_down <= 1'b1;
      repeat (10) @(posedge clk);
      power_down <= 1'b0;
      settle();
      chk(data_settings, cds_pkg::DATA_DEFAULT, "data after power down");
      chk(ctrl_settings, cds_pkg::CTRL_DEFAULT, "ctrl after power down");
      chk({signal_bits, adc_invalid_flag, overrange_flag}, 4'hE, "status after power down");
      $display("done power down");
   endtask

   task automatic end_sim();
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // system clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // main sequence
   initial begin
      reset_n = 1'b0;
      data_mode_pin = 1'b0;
      power_down = 1'b0;
      autocal_busy = 1'b0;
      adc_overrange = 1'b0;
      ext_pins = 2'h3;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_ctrl();
      t_data();
      t_status();
      t_pwrdn();
      end_sim();
   end

   // watchdog well beyond the expected few microseconds
   initial begin
      #50000;
      bad_count++;
      end_sim();
   end
endmodule

// ### pkg/cds_pkg.sv
// constants, field layouts, defaults and word decoders for the codec data word settings block
// assumes a 64-bit serial word, most significant bit first, as seen by the link logic
package cds_pkg;

   // word geometry
   localparam int WORD_BITS = 64;
   localparam logic [5:0] CNT_FIRST = 6'h00;
   localparam logic [5:0] CNT_LAST = 6'h3F;

   // data word field positions (lsb of each field)
   localparam int POS_OM = 30;
   localparam int POS_LO = 24;
   localparam int POS_ADI = 23;
   localparam int POS_SM = 22;
   localparam int POS_RO = 16;
   localparam int POS_PIO = 14;
   localparam int POS_OVR = 13;
   localparam int POS_IS = 12;
   localparam int POS_LG = 8;
   localparam int POS_MA = 4;
   localparam int POS_RG = 0;

   // control word field positions (lsb of each field)
   localparam int POS_MB = 60;
   localparam int POS_OLB = 59;
   localparam int POS_DCB = 58;
   localparam int POS_AC = 56;
   localparam int POS_DFR = 51;
   localparam int POS_ST = 50;
   localparam int POS_DF = 48;
   localparam int POS_ITS = 47;
   localparam int POS_MCK = 44;
   localparam int POS_FSEL = 42;
   localparam int POS_MS = 41;
   localparam int POS_TRANSMIT_DISABLE = 40;
   localparam int POS_ENL = 33;
   localparam int POS_ADL = 32;
   localparam int POS_CPIO = 30;

   // special codes
   localparam logic [5:0] ATTEN_MUTE = 6'h3F;
   localparam logic [3:0] MIX_OFF = 4'hF;
   localparam logic [3:0] REV_HIGH = 4'h2;

   // values after reset
   localparam logic [1:0] SIG_DEFAULT = 2'h3;
   localparam logic ADI_DEFAULT = 1'h1;
   localparam logic OVR_DEFAULT = 1'h0;

   // settings that the host may change in every data word
   typedef struct packed {
      logic [1:0] line_mute_n;
      logic [5:0] left_dac_atten;
      logic speaker_mute_n;
      logic [5:0] right_dac_atten;
      logic input_select;
      logic [3:0] left_in_gain;
      logic [3:0] monitor_mix_atten;
      logic [3:0] right_in_gain;
   } cds_data_set_type;

   // settings that only a control word, reset or power-down changes
   typedef struct packed {
      logic mic_boost_bypass;
      logic output_level_select;
      logic data_control_bit;
      logic autocal_enable;
      logic [2:0] rate_select;
      logic stereo_select;
      logic [1:0] sample_format;
      logic immediate_tristate;
      logic [2:0] clock_source_select;
      logic [1:0] frame_size_select;
      logic master_select;
      logic transmit_disable;
      logic loopback_enable;
      logic loopback_type;
   } cds_ctrl_set_type;

   localparam cds_data_set_type DATA_DEFAULT = '{
      line_mute_n: 2'h0, left_dac_atten: 6'h3F, speaker_mute_n: 1'h0,
      right_dac_atten: 6'h3F, input_select: 1'h0, left_in_gain: 4'h0,
      monitor_mix_atten: 4'hF, right_in_gain: 4'h0};

   localparam cds_ctrl_set_type CTRL_DEFAULT = '{
      mic_boost_bypass: 1'h0, output_level_select: 1'h0, data_control_bit: 1'h1,
      autocal_enable: 1'h0, rate_select: 3'h0, stereo_select: 1'h0,
      sample_format: 2'h1, immediate_tristate: 1'h0, clock_source_select: 3'h0,
      frame_size_select: 2'h2, master_select: 1'h0, transmit_disable: 1'h1,
      loopback_enable: 1'h0, loopback_type: 1'h0};

   // pick the data-mode settings out of a received word
   function automatic cds_data_set_type to_data_set(input logic [63:0] w);
      cds_data_set_type s;
      s.line_mute_n = w[POS_OM +: 2];
      s.left_dac_atten = w[POS_LO +: 6];
      s.speaker_mute_n = w[POS_SM];
      s.right_dac_atten = w[POS_RO +: 6];
      s.input_select = w[POS_IS];
      s.left_in_gain = w[POS_LG +: 4];
      s.monitor_mix_atten = w[POS_MA +: 4];
      s.right_in_gain = w[POS_RG +: 4];
      return s;
   endfunction

   // pick the control-mode settings out of a received word
   function automatic cds_ctrl_set_type to_ctrl_set(input logic [63:0] w);
      cds_ctrl_set_type s;
      s.mic_boost_bypass = w[POS_MB];
      s.output_level_select = w[POS_OLB];
      s.data_control_bit = w[POS_DCB];
      s.autocal_enable = w[POS_AC];
      s.rate_select = w[POS_DFR +: 3];
      s.stereo_select = w[POS_ST];
      s.sample_format = w[POS_DF +: 2];
      s.immediate_tristate = w[POS_ITS];
      s.clock_source_select = w[POS_MCK +: 3];
      s.frame_size_select = w[POS_FSEL +: 2];
      s.master_select = w[POS_MS];
      s.transmit_disable = w[POS_TRANSMIT_DISABLE];
      s.loopback_enable = w[POS_ENL];
      s.loopback_type = w[POS_ADL];
      return s;
   endfunction

endpackage

// ### src/cds_settings.sv
// settings bank of the codec serial port: word receive and transmit on the bit clock,
// settings, sticky status and defaults on the system clock
// assumes the host drives the bit clock and word start, and sclk may stop between words
//
// Contract
// - left dac attenuation code drives 1.5 dB steps; code 63 gives full digital mute
// - right dac attenuation code drives 1.5 dB steps; code 63 gives full digital mute
// - adc invalid flag reads 1 while autocalibration is running
// - speaker mute bit 0 mutes the mono speaker, 1 turns it on
// - signalling bits are stored and passed out only, steering nothing else
// - overrange flag is sticky on overrange, cleared by a written 0, a control-to-data change or power-down
// - input select 0 is line; 1 is mic boost unless boost bypass is set
// - left input gain code gives 1.5 dB steps up to 22.5 dB
// - right input gain code gives 1.5 dB steps up to 22.5 dB
// - monitor mix code gives 6 dB steps; code 15 turns monitor path off
// - reset or power-down exit loads the control-mode defaults
// - reset or power-down exit loads the data-word defaults
// - control-to-data change re-defaults data-only fields, keeps signalling bits
// - first data word after the change may override the fresh defaults
// - outgoing signalling bits carry the latest sampled pin levels, except in digital loopback
// - line mute bit 0 mutes its line output, 1 turns it on
// - incoming data sampled on falling sclk, outgoing driven on rising sclk
`timescale 1ns/1ps

module cds_settings #(
   parameter logic [3:0] REV_ID = 4'h2 // arbitrary revision value
) (
   // system clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // serial link, clocked by the host's bit clock
   input wire logic sclk,
   input wire logic serial_rx_data,
   input wire logic word_start_in,
   input wire logic data_mode_pin,
   output logic serial_tx_data,
   output logic serial_tx_oe,
   // open-collector signalling pins
   input wire logic [1:0] signal_pins_in,
   output logic [1:0] signal_pins_out,
   output logic [1:0] signal_pins_oe,
   // converter side status
   input wire logic power_down,
   input wire logic autocal_busy,
   input wire logic adc_overrange,
   // settings towards the analog paths
   output cds_pkg::cds_data_set_type data_settings,
   output cds_pkg::cds_ctrl_set_type ctrl_settings,
   output logic [1:0] signal_bits,
   output logic left_dac_mute,
   output logic right_dac_mute,
   output logic monitor_off,
   output logic mic_boost_on,
   output logic adc_invalid_flag,
   output logic overrange_flag,
   output logic data_mode
);

   // settings and status held on the system clock; ctrl_q, ovr_q and adi_q also read by the transmit side
   cds_pkg::cds_data_set_type data_q;
   cds_pkg::cds_ctrl_set_type ctrl_q;
   logic [1:0] sig_q;
   logic ovr_q, adi_q, busy_prev_q;

   // link domain, falling edge
   logic dm_l1_q, dm_l2_q;
   logic ws_prev_q, in_word_q;
   logic [5:0] bit_cnt_q;
   logic [63:0] shift_q, rx_hold_q;
   logic rx_mode_q, rx_tgl_q;
   logic word_start;
   logic word_end;

   // data/control pin into the link domain
   always_ff @(negedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         dm_l1_q <= 1'h0;
         dm_l2_q <= 1'h0;
      end else begin
         dm_l1_q <= data_mode_pin;
         dm_l2_q <= dm_l1_q;
      end
   end

   // word start is a low then high sample, looked at only when idle or on the last bit
   assign word_end = in_word_q & (bit_cnt_q == cds_pkg::CNT_LAST);
   assign word_start = word_start_in & ~ws_prev_q & (~in_word_q | word_end);

   // word framing and bit counter
   always_ff @(negedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         ws_prev_q <= 1'h1;
         in_word_q <= 1'h0;
         bit_cnt_q <= cds_pkg::CNT_FIRST;
      end else begin
         ws_prev_q <= word_start_in;
         if (word_start) begin
            in_word_q <= 1'h1;
            bit_cnt_q <= cds_pkg::CNT_FIRST;
         end else if (word_end) begin
            in_word_q <= 1'h0;
         end else if (in_word_q) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
         end
      end
   end

   // receive shift, msb first, sampled on the falling edge
   always_ff @(negedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         shift_q <= 64'h0;
      end else if (in_word_q) begin
         shift_q <= {shift_q[62:0], serial_rx_data};
      end
   end

   // finished word is held for a whole word time while the system side copies it
   always_ff @(negedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_hold_q <= 64'h0;
         rx_mode_q <= 1'h0;
         rx_tgl_q <= 1'h0;
      end else if (word_end) begin
         rx_hold_q <= {shift_q[62:0], serial_rx_data};
         rx_mode_q <= dm_l2_q;
         rx_tgl_q <= ~rx_tgl_q;
      end
   end

   // link domain, rising edge
   logic [1:0] pio_l1_q, pio_l2_q;
   logic transmit_disable_l1_q, transmit_disable_l2_q;
   logic loop_l1_q, loop_l2_q;
   logic ovr_l1_q, ovr_l2_q;
   logic adi_l1_q, adi_l2_q;
   logic [63:0] tx_snap_q;
   logic tx_data_q, tx_oe_q;
   logic [63:0] tx_frame;
   logic [5:0] tx_index;

   // pins and system-side levels into the link domain
   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         pio_l1_q <= cds_pkg::SIG_DEFAULT;
         pio_l2_q <= cds_pkg::SIG_DEFAULT;
         transmit_disable_l1_q <= 1'h1;
         transmit_disable_l2_q <= 1'h1;
         loop_l1_q <= 1'h0;
         loop_l2_q <= 1'h0;
         ovr_l1_q <= 1'h0;
         ovr_l2_q <= 1'h0;
         adi_l1_q <= 1'h1;
         adi_l2_q <= 1'h1;
      end else begin
         pio_l1_q <= signal_pins_in;
         pio_l2_q <= pio_l1_q;
         transmit_disable_l1_q <= ctrl_q.transmit_disable;
         transmit_disable_l2_q <= transmit_disable_l1_q;
         loop_l1_q <= ctrl_q.loopback_enable & ~ctrl_q.loopback_type;
         loop_l2_q <= loop_l1_q;
         ovr_l1_q <= ovr_q;
         ovr_l2_q <= ovr_l1_q;
         adi_l1_q <= adi_q;
         adi_l2_q <= adi_l1_q;
      end
   end

   // outgoing word: echo with pin levels and revision in control mode; low half only with pins and live status in data mode; loopback echoes it unchanged
   always_comb begin
      if (!dm_l2_q) begin
         tx_frame = {rx_hold_q[63:32], pio_l2_q, rx_hold_q[29:16],
                     cds_pkg::REV_HIGH, REV_ID, 8'h00};
      end else if (loop_l2_q) begin
         tx_frame = rx_hold_q; // digital loopback
      end else begin
         tx_frame = {32'h0, rx_hold_q[31:24], adi_l2_q, rx_hold_q[22:16],
                     pio_l2_q, ovr_l2_q, rx_hold_q[12:0]};
      end
   end

   assign tx_index = cds_pkg::CNT_LAST - bit_cnt_q;

   // transmit shift, driven on the rising edge; control mode drives through every word
   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_snap_q <= 64'h0;
         tx_data_q <= 1'h0;
         tx_oe_q <= 1'h0;
      end else begin
         if (in_word_q && bit_cnt_q == cds_pkg::CNT_FIRST) begin
            tx_snap_q <= tx_frame;
            tx_data_q <= tx_frame[cds_pkg::WORD_BITS - 1];
         end else begin
            tx_data_q <= tx_snap_q[tx_index];
         end
         tx_oe_q <= in_word_q & (~dm_l2_q | ~transmit_disable_l2_q);
      end
   end

   assign serial_tx_data = tx_data_q;
   assign serial_tx_oe = tx_oe_q;

   // system domain
   logic dm_s1_q, dm_s2_q, dm_s3_q;
   logic pd_s1_q, pd_s2_q;
   logic rt_s1_q, rt_s2_q, rt_s3_q;
   logic rx_new, to_data;

   // pin and link-toggle synchronisers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dm_s1_q <= 1'h0;
         dm_s2_q <= 1'h0;
         dm_s3_q <= 1'h0;
         pd_s1_q <= 1'h0;
         pd_s2_q <= 1'h0;
         rt_s1_q <= 1'h0;
         rt_s2_q <= 1'h0;
         rt_s3_q <= 1'h0;
      end else begin
         dm_s1_q <= data_mode_pin;
         dm_s2_q <= dm_s1_q;
         dm_s3_q <= dm_s2_q;
         pd_s1_q <= power_down;
         pd_s2_q <= pd_s1_q;
         rt_s1_q <= rx_tgl_q;
         rt_s2_q <= rt_s1_q;
         rt_s3_q <= rt_s2_q;
      end
   end

   // one-cycle events: a new word held stable, and a control-to-data change
   assign rx_new = rt_s2_q ^ rt_s3_q;
   assign to_data = dm_s2_q & ~dm_s3_q;

   // data-mode settings; a data word wins over the re-default in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_q <= cds_pkg::DATA_DEFAULT;
      end else if (pd_s2_q) begin
         data_q <= cds_pkg::DATA_DEFAULT;
      end else if (rx_new && rx_mode_q) begin
         data_q <= cds_pkg::to_data_set(rx_hold_q);
      end else if (to_data) begin
         data_q <= cds_pkg::DATA_DEFAULT;
      end
   end

   // control-mode settings, changed only by control words, reset and power-down
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= cds_pkg::CTRL_DEFAULT;
      end else if (pd_s2_q) begin
         ctrl_q <= cds_pkg::CTRL_DEFAULT;
      end else if (rx_new && !rx_mode_q) begin
         ctrl_q <= cds_pkg::to_ctrl_set(rx_hold_q);
      end
   end

   // signalling bits written in either word kind, untouched by the mode change
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sig_q <= cds_pkg::SIG_DEFAULT;
      end else if (pd_s2_q) begin
         sig_q <= cds_pkg::SIG_DEFAULT;
      end else if (rx_new) begin
         sig_q <= rx_mode_q ? rx_hold_q[cds_pkg::POS_PIO +: 2]
                            : rx_hold_q[cds_pkg::POS_CPIO +: 2];
      end
   end

   // sticky overrange: the event wins over a written 0, a written 1 does nothing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ovr_q <= cds_pkg::OVR_DEFAULT;
      end else if (pd_s2_q) begin
         ovr_q <= cds_pkg::OVR_DEFAULT;
      end else if (adc_overrange) begin
         ovr_q <= 1'h1;
      end else if (rx_new && rx_mode_q && !rx_hold_q[cds_pkg::POS_OVR]) begin
         ovr_q <= 1'h0;
      end else if (to_data) begin
         ovr_q <= 1'h0;
      end
   end

   // adc invalid follows calibration and ignores the host
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         adi_q <= cds_pkg::ADI_DEFAULT;
         busy_prev_q <= 1'h0;
      end else begin
         busy_prev_q <= autocal_busy;
         if (pd_s2_q || autocal_busy) begin
            adi_q <= 1'h1;
         end else if (busy_prev_q) begin
            adi_q <= 1'h0;
         end
      end
   end

   // registered outputs towards the analog paths
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_settings <= cds_pkg::DATA_DEFAULT;
         ctrl_settings <= cds_pkg::CTRL_DEFAULT;
         signal_bits <= cds_pkg::SIG_DEFAULT;
         left_dac_mute <= 1'h1;
         right_dac_mute <= 1'h1;
         monitor_off <= 1'h1;
         mic_boost_on <= 1'h0;
         adc_invalid_flag <= cds_pkg::ADI_DEFAULT;
         overrange_flag <= cds_pkg::OVR_DEFAULT;
         data_mode <= 1'h0;
      end else begin
         data_settings <= data_q;
         ctrl_settings <= ctrl_q;
         signal_bits <= sig_q;
         left_dac_mute <= data_q.left_dac_atten == cds_pkg::ATTEN_MUTE;
         right_dac_mute <= data_q.right_dac_atten == cds_pkg::ATTEN_MUTE;
         monitor_off <= data_q.monitor_mix_atten == cds_pkg::MIX_OFF;
         mic_boost_on <= data_q.input_select & ~ctrl_q.mic_boost_bypass;
         adc_invalid_flag <= adi_q;
         overrange_flag <= ovr_q;
         data_mode <= dm_s2_q;
      end
   end

   // open-collector pins: low while the stored bit is 0, released while 1
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         signal_pins_out <= 2'h0;
         signal_pins_oe <= 2'h0;
      end else begin
         signal_pins_out <= 2'h0;
         signal_pins_oe <= ~sig_q;
      end
   end

endmodule
